// ---- hw/ccmnb_top.sv ----
// CCM initialization vector builder with per-context packet counters
`timescale 1ns/10ps

// How it works
// - identity word fills octets 8 to 11
// - keep only twelve low fixed-side identity bits
// - fixed identity top eight octet 8, rest octet 9
// - portable identity split across octets 9 to 11
// - portable bit one is the most significant
// - transmit and receive keep separate contexts
// - link connection index in octet 12 low bits
// - octet 12 bits 6 to 3 zero
// - direction bit: fixed-to-portable zero, else one
// - packet number is a 48-bit counter
// - low packet bits equal first-segment sequence number
// - explicit part eight bits, nine in long format
// - upper bits kept locally, bumped on wrap
// - receiver rebuilds from previous number plus wrap
// - no vector for an unopened context
// - missing key aborts setup with error code
// - one multicast instance per channel, one direction
// - multicast contexts always use long format
// - each multicast instance has its own counter
// - multicast transmit waits for key delivery
// - octet 0 is flag value 09 hex
// - packet number big-endian in octets 2 to 7
// - octet 13 all zero
// - unit length big-endian in octets 14 and 15
module ccmnb_top
	import ccmnb_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic fixed_side_i,
	input wire logic [11:0] fixed_side_access_id_i,
	input wire logic [19:0] portable_short_id_i,
	input wire logic [2:0] link_connection_index_i,
	input wire logic long_frame_format_i,
	input wire logic mc_key_delivered_i,
	input wire logic setup_req_i,
	input wire logic [2:0] setup_ctx_i,
	input wire logic [47:0] setup_pn_i,
	input wire logic setup_key_ok_i,
	input wire logic close_req_i,
	input wire logic [2:0] close_ctx_i,
	input wire logic req_valid_i,
	input wire logic [2:0] req_ctx_i,
	input wire logic [8:0] link_sequence_number_i,
	input wire logic [15:0] sdu_len_i,
	output logic req_ready_o,
	output logic [127:0] iv_o,
	output logic iv_valid_o,
	output logic [47:0] pn_o,
	output logic pn_valid_o,
	output logic req_err_o,
	output logic setup_done_o,
	output logic setup_abort_o,
	output logic [1:0] setup_err_code_o,
	output logic [5:0] ctx_open_o
);

	typedef struct packed {
		logic [5:0][47:0] pn;
		logic [5:0] open;
		logic [5:0] fresh;
		logic [127:0] iv;
		logic iv_valid;
		logic [47:0] pn_out;
		logic pn_valid;
		logic err;
		logic done;
		logic abort;
		logic [1:0] code;
	} ccmnb_state_t;

	ccmnb_state_t st_r;
	ccmnb_state_t st_nxt;
	logic acc;
	logic is_mc;
	logic long_sel;
	logic [47:0] pn_ext;
	logic wrap;
	logic dir_bit;
	logic req_ok;

	// Multicast index check, used by the request path only
	function automatic logic ccmnb_is_mc(input logic [2:0] ctx);
		return (ctx >= CTX_MC_FIRST) && (ctx <= CTX_MC_LAST);
	endfunction

	// Setup wins the cycle, so a request waits rather than racing a reload
	assign req_ready_o = ~setup_req_i;
	assign acc = req_valid_i & req_ready_o;
	assign is_mc = ccmnb_is_mc(req_ctx_i);
	assign long_sel = is_mc | long_frame_format_i;

	// closed context refused
	// On a multicast channel the fixed side is refused until mc_key_delivered_i; a portable is not gated
	assign req_ok = (req_ctx_i < CTX_N[2:0]) && st_r.open[req_ctx_i] &&
		!(is_mc && fixed_side_i && !mc_key_delivered_i);

	// each direction keeps its own context
	assign dir_bit = (req_ctx_i == CTX_CO_TX) ? ~fixed_side_i : fixed_side_i;

	ccmnb_pn_ext u_pn_ext (
		.prev_pn_i(st_r.pn[req_ctx_i]),
		.seq_i(link_sequence_number_i),
		.long_i(long_sel),
		.fresh_i(st_r.fresh[req_ctx_i]),
		.pn_o(pn_ext),
		.wrap_o(wrap)
	);

	// Next state: close, setup, then vector requests
	always_comb begin
		st_nxt = st_r;
		st_nxt.iv_valid = 1'b0;
		st_nxt.pn_valid = 1'b0;
		st_nxt.err = 1'b0;
		st_nxt.done = 1'b0;
		st_nxt.abort = 1'b0;
		if (close_req_i && close_ctx_i < CTX_N[2:0]) begin
			st_nxt.open[close_ctx_i] = 1'b0;
		end
		if (setup_req_i) begin
			if (setup_key_ok_i && setup_ctx_i < CTX_N[2:0]) begin
				st_nxt.open[setup_ctx_i] = 1'b1;
				st_nxt.fresh[setup_ctx_i] = 1'b1;
				st_nxt.pn[setup_ctx_i] = setup_pn_i;
				st_nxt.done = 1'b1;
				st_nxt.code = ERR_NONE;
			end else begin
				st_nxt.abort = 1'b1;
				st_nxt.code = ERR_NO_KEY;
			end
		end
		if (acc) begin
			if (req_ok) begin
				st_nxt.pn[req_ctx_i] = pn_ext;
				st_nxt.fresh[req_ctx_i] = 1'b0;
				st_nxt.pn_out = pn_ext;
				st_nxt.pn_valid = 1'b1;
				// multicast vectors use another layout, so only the number
				st_nxt.iv_valid = ~is_mc;
				// octet 0 in the top byte
				st_nxt.iv[POS_FLAGS +: 8] = IV_FLAGS;
				st_nxt.iv[POS_NRSV +: 8] = IV_NONCE_RSV;
				st_nxt.iv[POS_PN +: 48] = pn_ext;
				st_nxt.iv[POS_FID +: 12] = fixed_side_access_id_i;
				st_nxt.iv[POS_PID +: 20] = portable_short_id_i;
				st_nxt.iv[POS_DIR] = dir_bit;
				st_nxt.iv[POS_RSV +: 4] = IV_CO_RSV;
				st_nxt.iv[POS_LCI +: 3] = link_connection_index_i;
				st_nxt.iv[POS_FIXED +: 8] = IV_FIXED_OCT;
				st_nxt.iv[POS_LEN +: 16] = sdu_len_i;
			end else begin
				st_nxt.err = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign iv_o = st_r.iv;
	assign iv_valid_o = st_r.iv_valid;
	assign pn_o = st_r.pn_out;
	assign pn_valid_o = st_r.pn_valid;
	assign req_err_o = st_r.err;
	assign setup_done_o = st_r.done;
	assign setup_abort_o = st_r.abort;
	assign setup_err_code_o = st_r.code;
	assign ctx_open_o = st_r.open;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	logic good;
	assign good = acc && req_ok;

	property p_flag;
		iv_valid_o |-> iv_o[127:120] == 8'h09 && iv_o[119:112] == 8'h00;
	endproperty
	a_flag: assert property (p_flag) else $error("flag octet wrong");

	property p_fixed;
		good && !is_mc |=> iv_valid_o && iv_o[23:16] == 8'h00;
	endproperty
	a_fixed: assert property (p_fixed) else $error("octet 13 not zero");

	property p_rsv;
		iv_valid_o |-> iv_o[30:27] == 4'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");

	property p_dir;
		good && req_ctx_i == CTX_CO_TX |=> iv_o[31] == !$past(fixed_side_i);
	endproperty
	a_dir: assert property (p_dir) else $error("direction bit wrong");

	property p_len;
		good && !is_mc |=> iv_o[15:0] == $past(sdu_len_i);
	endproperty
	a_len: assert property (p_len) else $error("length octets wrong");

	property p_low;
		good |=> pn_valid_o && pn_o[7:0] == $past(link_sequence_number_i[7:0]);
	endproperty
	a_low: assert property (p_low) else $error("low packet bits wrong");

	property p_mclong;
		good && is_mc |=> pn_o[8:0] == $past(link_sequence_number_i);
	endproperty
	a_mclong: assert property (p_mclong) else $error("multicast not long");

	// nine explicit bits on a long-format connection
	property p_colong;
		good && !is_mc && long_frame_format_i |=>
			pn_o[8:0] == $past(link_sequence_number_i);
	endproperty
	a_colong: assert property (p_colong) else $error("long format not nine bits");

	property p_fid;
		good && !is_mc |=> iv_o[63:52] == $past(fixed_side_access_id_i);
	endproperty
	a_fid: assert property (p_fid) else $error("fixed identity misplaced");

	property p_pid;
		good && !is_mc |=> iv_o[51:32] == $past(portable_short_id_i);
	endproperty
	a_pid: assert property (p_pid) else $error("portable identity misplaced");

	property p_lci;
		good && !is_mc |=> iv_o[26:24] == $past(link_connection_index_i);
	endproperty
	a_lci: assert property (p_lci) else $error("connection index wrong");

	property p_abort;
		setup_req_i && !setup_key_ok_i |=> setup_abort_o && setup_err_code_o == ERR_NO_KEY
			&& !setup_done_o;
	endproperty
	a_abort: assert property (p_abort) else $error("setup not aborted");

	property p_closed;
		acc && !req_ok |=> req_err_o && !iv_valid_o && !pn_valid_o;
	endproperty
	a_closed: assert property (p_closed) else $error("vector for closed context");

	property p_wrap;
		good && !long_sel && wrap |=>
			pn_o[47:8] == $past(st_r.pn[req_ctx_i][47:8]) + 40'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("upper part not bumped");

	property p_mckey;
		acc && is_mc && fixed_side_i && !mc_key_delivered_i |=> !pn_valid_o;
	endproperty
	a_mckey: assert property (p_mckey) else $error("multicast sent before key");

	// Main scenarios
	c_co_iv: cover property (good && !is_mc ##1 iv_valid_o);
	c_wrap: cover property (good && wrap);
	c_abort: cover property (setup_req_i && !setup_key_ok_i);
	c_mc: cover property (good && is_mc);
	c_long: cover property (good && !is_mc && long_frame_format_i);

endmodule // ccmnb_top

// ---- hw/ccmnb_pkg.sv ----
// Constants for the CCM nonce builder
package ccmnb_pkg;

	// Clock rate in megahertz
	localparam int unsigned CLK_MHZ = 250;

	// Context map: own transmit, peer receive, then multicast instances
	localparam int unsigned CTX_N = 6;
	localparam int unsigned CTX_W = 3;
	localparam logic [2:0] CTX_CO_TX = 3'h0;
	localparam logic [2:0] CTX_CO_RX = 3'h1;
	localparam logic [2:0] CTX_MC_FIRST = 3'h2;
	localparam logic [2:0] CTX_MC_LAST = 3'h5;

	// Packet number layout
	localparam int unsigned PN_W = 48;
	localparam int unsigned SN_SHORT_W = 8;
	localparam int unsigned SN_LONG_W = 9;
	localparam logic [47:0] PN_RST = 48'h0000_0000_0000;

	// Identity widths
	localparam int unsigned FIXED_ID_W = 12;
	localparam int unsigned PORT_ID_W = 20;
	localparam int unsigned LCI_W = 3;

	// Initialization vector constant octets
	localparam int unsigned IV_W = 128;
	localparam logic [7:0] IV_FLAGS = 8'h09;
	localparam logic [7:0] IV_NONCE_RSV = 8'h00;
	localparam logic [7:0] IV_FIXED_OCT = 8'h00;
	localparam logic [3:0] IV_CO_RSV = 4'h0;
	localparam logic DIR_FIXED_TO_PORT = 1'b0;
	localparam logic DIR_PORT_TO_FIXED = 1'b1;

	// Field positions inside the 128-bit vector, octet 0 in the top byte
	localparam int unsigned POS_FLAGS = 120;
	localparam int unsigned POS_NRSV = 112;
	localparam int unsigned POS_PN = 64;
	localparam int unsigned POS_FID = 52;
	localparam int unsigned POS_PID = 32;
	localparam int unsigned POS_DIR = 31;
	localparam int unsigned POS_RSV = 27;
	localparam int unsigned POS_LCI = 24;
	localparam int unsigned POS_FIXED = 16;
	localparam int unsigned POS_LEN = 0;

	// Setup error codes
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_NO_KEY = 2'h1;

endpackage

// ---- hw/ccmnb_pn_ext.sv ----
// Packet number extension from a link sequence number
`timescale 1ns/10ps
module ccmnb_pn_ext
	import ccmnb_pkg::*;
(
	input wire logic [47:0] prev_pn_i,
	input wire logic [8:0] seq_i,
	input wire logic long_i,
	input wire logic fresh_i,
	output logic [47:0] pn_o,
	output logic wrap_o
);
	logic [38:0] up_long;
	logic [39:0] up_short;

	// Upper parts kept locally, never on the air
	assign up_long = prev_pn_i[47:9];
	assign up_short = prev_pn_i[47:8];

	// Wrap when the new sequence does not move past the old low part;
	// a freshly opened context may reuse its loaded value once
	always_comb begin
		wrap_o = 1'b0;
		pn_o = prev_pn_i;
		if (long_i) begin
			wrap_o = fresh_i ? (seq_i < prev_pn_i[8:0]) : (seq_i <= prev_pn_i[8:0]);
			pn_o = {up_long + {38'h0, wrap_o}, seq_i};
		end else begin
			wrap_o = fresh_i ? (seq_i[7:0] < prev_pn_i[7:0]) :
				(seq_i[7:0] <= prev_pn_i[7:0]);
			pn_o = {up_short + {39'h0, wrap_o}, seq_i[7:0]};
		end
	end
endmodule // ccmnb_pn_ext

// ---- verif/ccmnb_peer_model.sv ----
// Remote peer model: full packet counter and the sequence number it sends
`timescale 1ns/10ps
module ccmnb_peer_model (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic load_i,
	input wire logic [47:0] load_pn_i,
	input wire logic step_i,
	input wire logic [8:0] step_by_i,
	output logic [8:0] sn_o,
	output logic [47:0] pn_o
);
	logic [47:0] pn_r;

	// Full 48-bit count kept here, upper part never sent
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pn_r <= 48'h0000_0000_0000;
		end else if (load_i) begin
			pn_r <= load_pn_i;
		end else if (step_i) begin
			pn_r <= pn_r + {39'h0, step_by_i};
		end
	end

	// Only the low bits go on the air
	assign sn_o = pn_r[8:0];
	assign pn_o = pn_r;
endmodule // ccmnb_peer_model

// ---- verif/test_ccm_nonce_builder.sv ----
// Self-checking bench for the CCM nonce builder
`timescale 1ns/10ps
module test_ccm_nonce_builder;
	import ccmnb_pkg::*;
	logic clk, rstn, fside, lff, mckey, sreq, skey, creq, rv, pload, pstep;
	logic [2:0] sctx, cctx, rctx;
	logic [47:0] spn, ppn, peer_pn, pn;
	logic [8:0] pby, sn;
	logic [15:0] len;
	logic [11:0] fid;
	logic [19:0] pid;
	logic [2:0] lci;
	logic rdy, ivv, pnv, rerr, sdone, sabort;
	logic [127:0] iv;
	logic [1:0] ecode;
	logic [5:0] copen;
	int failures;
	int checks_done;

	ccmnb_top uut (.sys_clk_i(clk), .rstn_i(rstn), .fixed_side_i(fside),
		.fixed_side_access_id_i(fid), .portable_short_id_i(pid),
		.link_connection_index_i(lci), .long_frame_format_i(lff),
		.mc_key_delivered_i(mckey), .setup_req_i(sreq), .setup_ctx_i(sctx),
		.setup_pn_i(spn), .setup_key_ok_i(skey), .close_req_i(creq),
		.close_ctx_i(cctx), .req_valid_i(rv), .req_ctx_i(rctx),
		.link_sequence_number_i(sn), .sdu_len_i(len), .req_ready_o(rdy),
		.iv_o(iv), .iv_valid_o(ivv), .pn_o(pn), .pn_valid_o(pnv),
		.req_err_o(rerr), .setup_done_o(sdone), .setup_abort_o(sabort),
		.setup_err_code_o(ecode), .ctx_open_o(copen));

	ccmnb_peer_model peer (.sys_clk_i(clk), .rstn_i(rstn), .load_i(pload),
		.load_pn_i(ppn), .step_i(pstep), .step_by_i(pby), .sn_o(sn),
		.pn_o(peer_pn));

	// Free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Expected vector from the field layout, octet 0 on top
	function automatic logic [127:0] mk(input logic d, input logic [47:0] p,
		input logic [15:0] n);
		mk = {8'h09, 8'h00, p, fid, pid, d, 4'h0, lci, 8'h00, n};
	endfunction

	// Request held until the taking edge, answer read in the pulse cycle
	task automatic do_setup(input logic [2:0] c, input logic [47:0] p, input logic k);
		@(negedge clk);
		sreq = 1'b1;
		sctx = c;
		spn = p;
		skey = k;
		@(posedge clk);
		@(negedge clk);
		sreq = 1'b0;
	endtask

	task automatic do_req(input logic [2:0] c, input logic [15:0] n);
		@(negedge clk);
		rv = 1'b1;
		rctx = c;
		len = n;
		@(posedge clk);
		@(negedge clk);
		rv = 1'b0;
	endtask

	task automatic peer_set(input logic [47:0] p, input logic [8:0] d);
		@(negedge clk);
		pload = 1'b1;
		ppn = p;
		@(negedge clk);
		pload = 1'b0;
		pstep = 1'b1;
		pby = d;
		@(negedge clk);
		pstep = 1'b0;
	endtask

	task automatic t_setup();
		chk("open_rst", 6'h00, copen);
		do_setup(3'h0, 48'h0000_0000_0010, 1'b1);
		chk("done", 1'b1, sdone);
		chk("open0", 6'h01, copen);
		do_setup(3'h4, 48'h0000_0000_0000, 1'b0);
		chk("abort", 1'b1, sabort);
		chk("code", ERR_NO_KEY, ecode);
		chk("open_kept", 6'h01, copen);
		// Setup cycle holds off a pending request for one edge
		@(negedge clk);
		sreq = 1'b1;
		sctx = 3'h5;
		spn = 48'h0000_0000_0000;
		skey = 1'b1;
		rv = 1'b1;
		rctx = 3'h1;
		#1;
		chk("rdy_setup", 1'b0, rdy);
		@(negedge clk);
		sreq = 1'b0;
		chk("held_err", 1'b0, rerr);
		chk("held_done", 1'b1, sdone);
		#1;
		chk("rdy_free", 1'b1, rdy);
		@(negedge clk);
		rv = 1'b0;
		chk("taken_err", 1'b1, rerr);
	endtask

	task automatic t_conn();
		do_setup(3'h1, 48'h0000_0000_01f0, 1'b1);
		peer_set(48'h0000_0000_01f0, 9'h008);
		do_req(3'h1, 16'h0001);
		chk("ivv_rx", 1'b1, ivv);
		chk("iv_rx", mk(1'b1, 48'h0000_0000_01f8, 16'h0001), iv);
		chk("pn_rx", 48'h0000_0000_01f8, pn);
		// Low byte falls back: upper part must advance
		peer_set(peer_pn, 9'h00d);
		do_req(3'h1, 16'h0002);
		chk("pn_wrap", 48'h0000_0000_0205, pn);
		// Long format: bit 8 of the sequence is explicit too
		lff = 1'b1;
		peer_set(peer_pn, 9'h1f0);
		do_req(3'h1, 16'h0003);
		chk("pn_long", 48'h0000_0000_03f5, pn);
		lff = 1'b0;
		peer_set(48'h0000_0000_0011, 9'h000);
		do_req(3'h0, 16'hffff);
		chk("iv_tx", mk(1'b0, 48'h0000_0000_0011, 16'hffff), iv);
		chk("pnv_tx", 1'b1, pnv);
		// Portable side: its own transmit goes uplink
		fside = 1'b0;
		peer_set(48'h0000_0000_0011, 9'h022);
		do_req(3'h0, 16'h0005);
		chk("iv_pp", mk(1'b1, 48'h0000_0000_0033, 16'h0005), iv);
		fside = 1'b1;
	endtask

	task automatic t_mcast();
		do_setup(3'h2, 48'h0000_0000_03f0, 1'b1);
		peer_set(48'h0000_0000_03f0, 9'h115);
		do_req(3'h2, 16'h0010);
		chk("mc_gate", 1'b1, rerr);
		chk("mc_gate_pn", 1'b0, pnv);
		mckey = 1'b1;
		do_req(3'h2, 16'h0010);
		chk("mc_pnv", 1'b1, pnv);
		chk("mc_ivv", 1'b0, ivv);
		chk("mc_pn", 48'h0000_0000_0505, pn);
		// Second instance starts from its own loaded count
		do_setup(3'h3, 48'h0000_0000_0000, 1'b1);
		do_req(3'h3, 16'h0010);
		chk("mc_own", 48'h0000_0000_0105, pn);
	endtask

	task automatic t_refuse();
		@(negedge clk);
		creq = 1'b1;
		cctx = 3'h0;
		@(negedge clk);
		creq = 1'b0;
		chk("closed", 1'b0, copen[0]);
		do_req(3'h0, 16'h0004);
		chk("err_closed", 1'b1, rerr);
		do_req(3'h6, 16'h0004);
		chk("err_ctx", 1'b1, rerr);
		chk("pn_hold", 48'h0000_0000_0105, pn);
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Main sequence: fixed side, fixed identities at boundary-ish values
	initial begin
		failures = 0;
		checks_done = 0;
		rstn = 1'b0;
		{fside, lff, mckey, sreq, skey, creq, rv, pload, pstep} = 9'h100;
		{sctx, cctx, rctx, pby} = 18'h0;
		{spn, ppn} = 96'h0;
		len = 16'h0001;
		fid = 12'habc;
		pid = 20'h5a3c1;
		lci = 3'h5;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		t_setup();
		t_conn();
		t_mcast();
		t_refuse();
		report_and_stop();
	end

	// Watchdog well beyond the few dozen cycles of the run
	initial begin
		#40000;
		failures++;
		report_and_stop();
	end
endmodule // test_ccm_nonce_builder
